// *** include/lmp_pkg.sv ***
// Shared constants, register map and types of the link status monitor
package lmp_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int unsigned LMP_CLK_HZ = 25_000_000; // System clock rate
  localparam int unsigned LMP_TICK_S = 1; // Timer tick period in seconds
  localparam int unsigned LMP_TICK_CYCLES = LMP_CLK_HZ * LMP_TICK_S; // Cycles per tick

  // ***************************************************
  // Parameter defaults and ranges
  // ***************************************************
  localparam logic [7:0] LMP_FULL_POLL_DEF = 8'h06; // Full status every 6 polls
  localparam logic [7:0] LMP_FULL_POLL_MIN = 8'h01;
  localparam logic [7:0] LMP_FULL_POLL_MAX = 8'hFF;
  localparam logic [7:0] LMP_ERR_THR_DEF = 8'h03; // Errors that fail the link
  localparam logic [7:0] LMP_WINDOW_DEF = 8'h04; // Monitored events
  localparam logic [7:0] LMP_CNT_MIN = 8'h01;
  localparam logic [7:0] LMP_CNT_MAX = 8'h0A;
  localparam logic [7:0] LMP_POLL_T_DEF = 8'h0A; // Poll timer, seconds
  localparam logic [7:0] LMP_VERIFY_T_DEF = 8'h0F; // Verify timer, seconds
  localparam logic [7:0] LMP_TIMER_MIN = 8'h05;
  localparam logic [7:0] LMP_TIMER_MAX = 8'h1E;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [11:0] LMP_CFG_OFS = 12'h000; // Counts and timers
  localparam logic [11:0] LMP_CTRL_OFS = 12'h004; // Enables and local status
  localparam logic [11:0] LMP_STAT_OFS = 12'h008; // Monitor state, read only
  // Configuration field positions
  localparam int LMP_CFG_FULL_LSB = 0;
  localparam int LMP_CFG_THR_LSB = 8;
  localparam int LMP_CFG_WIN_LSB = 12;
  localparam int LMP_CFG_POLL_LSB = 16;
  localparam int LMP_CFG_VER_LSB = 24;
  // Control bit positions
  localparam int LMP_CTRL_EN = 0; // Procedures running; low clears all procedure state but the pending report flags and the last status
  localparam int LMP_CTRL_FAST = 1; // A valid first event brings the link side up
  localparam int LMP_CTRL_SEG_CFG = 2; // Local segment configured
  localparam int LMP_CTRL_SEG_OK = 3; // Local segment free of faults
  localparam int LMP_CTRL_UNI_OK = 4; // Local user interface operational
  localparam int LMP_CTRL_UP_ACT = 5; // Active bit from the user side
  localparam logic [31:0] LMP_CTRL_RST = 32'h0000_0000;
  // Status bit positions
  localparam int LMP_ST_USER_OP = 0;
  localparam int LMP_ST_NET_OP = 1;
  localparam int LMP_ST_PRESENT = 2;
  localparam int LMP_ST_ACTIVE = 3;
  localparam int LMP_ST_ADDED = 4;
  localparam int LMP_ST_UERR_LSB = 8;
  localparam int LMP_ST_NERR_LSB = 12;

  // ***************************************************
  // Types
  // ***************************************************
  // One cycle of link traffic in one direction
  typedef struct packed {
    logic enq; // Status enquiry pulse
    logic enq_full; // Enquiry asks for a full report
    logic [7:0] enq_seq; // Enquiry sequence number
    logic rep; // Status report pulse
    logic rep_full; // Report is a full report
    logic [7:0] rep_ack; // Echo of the enquiry sequence
    logic present; // Segment element present
    logic active; // Active bit
    logic added; // New bit
  } lmp_msg_s;

  // Link integrity monitor state of one procedure side
  typedef struct packed {
    logic [9:0] hist; // Last events, 1 is an error
    logic [3:0] good; // Consecutive valid events
    logic fresh; // No event seen yet
    logic op; // Side operational
  } lmp_mon_s;

  localparam lmp_mon_s LMP_MON_RST = '{hist: 10'h000, good: 4'h0, fresh: 1'b1, op: 1'b0};

  // Errors among the newest win events
  function automatic logic [3:0] lmp_errs(logic [9:0] hist, logic [3:0] win);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++)
    begin
      if ((i < int'(win)) && hist[i])
      begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction : lmp_errs

  // Account one monitored event
  function automatic lmp_mon_s lmp_event(lmp_mon_s m, logic err, logic fast,
                                         logic [3:0] thr, logic [3:0] win);
    lmp_mon_s r;
    r = m;
    r.hist = {m.hist[8:0], err};
    r.fresh = 1'b0;
    if (err)
    begin
      r.good = 4'h0;
      if (lmp_errs(r.hist, win) >= thr)
      begin
        r.op = 1'b0;
      end
    end
    else
    begin
      if (m.good != 4'hF)
      begin
        r.good = m.good + 4'h1;
      end
      if ((r.good >= win) || (fast && m.fresh))
      begin
        r.op = 1'b1;
      end
    end
    return r;
  endfunction : lmp_event

  // Clamp a written value into its legal range
  function automatic logic [7:0] lmp_clamp(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lmp_clamp

endpackage : lmp_pkg

// *** include/lmp_link_if.sv ***
// Link between the two network ends, one message bundle per direction
interface lmp_link_if
  import lmp_pkg::*;
(
  input wire logic pclk
);
  lmp_msg_s d2p; // Monitor end toward peer end
  lmp_msg_s p2d; // Peer end toward monitor end

  modport dev(input pclk, output d2p, input p2d);
  modport peer(input pclk, input d2p, output p2d);
endinterface : lmp_link_if

// *** hw/lmp_monitor.sv ***
// Link integrity and connection status monitor with APB registers
module lmp_monitor
  import lmp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LMP_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lmp_link_if.dev link,
  output logic fwd_present,
  output logic fwd_active,
  output logic fwd_added
);

  // ***************************************************
  // Register file
  // ***************************************************
  logic [31:0] cfg; // Counts and timers
  logic [31:0] ctrl; // Enables and local status
  logic [31:0] next_cfg;
  logic [31:0] next_ctrl;
  logic [31:0] next_prdata;
  logic mapped; // Address hits a register
  logic [31:0] stat; // Live status word
  logic [3:0] thr; // Error threshold count
  logic [3:0] win; // Monitored event window
  logic [7:0] full_n; // Full status poll count
  logic en; // Procedures enabled
  logic crit; // Local active criteria

  assign mapped = (paddr == LMP_CFG_OFS) || (paddr == LMP_CTRL_OFS) || (paddr == LMP_STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign full_n = cfg[LMP_CFG_FULL_LSB +: 8];
  assign thr = cfg[LMP_CFG_THR_LSB +: 4];
  assign win = cfg[LMP_CFG_WIN_LSB +: 4];
  assign en = ctrl[LMP_CTRL_EN];

  // Decode writes with range clamping; read data is fetched in setup
  always_comb
  begin
    next_cfg = cfg;
    next_ctrl = ctrl;
    next_prdata = prdata;
    if (psel && penable && pwrite)
    begin
      if (paddr == LMP_CFG_OFS)
      begin
        // Counts and timers kept inside their legal ranges
        next_cfg = 32'h0000_0000;
        next_cfg[LMP_CFG_FULL_LSB +: 8] = lmp_clamp(pwdata[LMP_CFG_FULL_LSB +: 8],
          LMP_FULL_POLL_MIN, LMP_FULL_POLL_MAX);
        next_cfg[LMP_CFG_THR_LSB +: 4] = 4'(lmp_clamp({4'h0, pwdata[LMP_CFG_THR_LSB +: 4]},
          LMP_CNT_MIN, LMP_CNT_MAX));
        next_cfg[LMP_CFG_WIN_LSB +: 4] = 4'(lmp_clamp({4'h0, pwdata[LMP_CFG_WIN_LSB +: 4]},
          LMP_CNT_MIN, LMP_CNT_MAX));
        next_cfg[LMP_CFG_POLL_LSB +: 5] = 5'(lmp_clamp({3'h0, pwdata[LMP_CFG_POLL_LSB +: 5]},
          LMP_TIMER_MIN, LMP_TIMER_MAX));
        next_cfg[LMP_CFG_VER_LSB +: 5] = 5'(lmp_clamp({3'h0, pwdata[LMP_CFG_VER_LSB +: 5]},
          LMP_TIMER_MIN, LMP_TIMER_MAX));
      end
      else if (paddr == LMP_CTRL_OFS)
      begin
        next_ctrl = {26'h0, pwdata[5:0]};
      end
    end
    if (psel && !penable)
    begin
      unique case (paddr)
        LMP_CFG_OFS: next_prdata = cfg;
        LMP_CTRL_OFS: next_prdata = ctrl;
        LMP_STAT_OFS: next_prdata = stat;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops; defaults match the documented parameter set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= {3'h0, LMP_VERIFY_T_DEF[4:0], 3'h0, LMP_POLL_T_DEF[4:0], LMP_WINDOW_DEF[3:0],
        LMP_ERR_THR_DEF[3:0], LMP_FULL_POLL_DEF};
      ctrl <= LMP_CTRL_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      cfg <= next_cfg;
      ctrl <= next_ctrl;
      prdata <= next_prdata;
    end
  end

  // ***************************************************
  // Second tick, poll side and answer side
  // ***************************************************
  logic [31:0] tick_cnt; // Cycles within the current second
  logic tick; // One-second strobe
  logic [4:0] poll_sec; // Poll timer seconds
  logic [7:0] poll_no; // Polls since last full request
  logic [7:0] tx_seq; // Last enquiry sequence sent
  logic wait_rep; // Enquiry outstanding
  lmp_mon_s umon; // Poll side link monitor
  logic [4:0] ver_sec; // Verify timer seconds
  lmp_mon_s nmon; // Answer side link monitor
  logic pend; // Change awaits a full report
  logic added_pend; // New bit still to report
  logic [1:0] last; // Sent status last cycle
  lmp_msg_s tx; // Outgoing message
  logic [31:0] next_tick_cnt;
  logic [4:0] next_poll_sec;
  logic [7:0] next_poll_no;
  logic [7:0] next_tx_seq;
  logic next_wait_rep;
  lmp_mon_s next_umon;
  logic [4:0] next_ver_sec;
  lmp_mon_s next_nmon;
  logic next_pend;
  logic next_added_pend;
  logic [1:0] next_last;
  lmp_msg_s next_tx;
  logic next_fwd_present;
  logic next_fwd_active;
  logic next_fwd_added;
  logic rx_ok; // Valid report for the outstanding enquiry

  assign tick = (tick_cnt == TICK_CYCLES - 1);
  assign rx_ok = link.p2d.rep && wait_rep && (link.p2d.rep_ack == tx_seq);
  // Local criteria; the received active bit plays no part here
  assign crit = ctrl[LMP_CTRL_SEG_CFG] && ctrl[LMP_CTRL_SEG_OK] && ctrl[LMP_CTRL_UNI_OK]
    && umon.op && nmon.op;
  assign stat = {16'h0, lmp_errs(nmon.hist, win), lmp_errs(umon.hist, win), 3'h0,
    fwd_added, fwd_active, fwd_present, nmon.op, umon.op};
  assign link.d2p = tx;

  // Both procedure sides advance every cycle side by side
  always_comb
  begin
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_poll_sec = poll_sec;
    next_poll_no = poll_no;
    next_tx_seq = tx_seq;
    next_wait_rep = wait_rep;
    next_umon = umon;
    next_ver_sec = ver_sec;
    next_nmon = nmon;
    next_pend = pend;
    next_added_pend = added_pend;
    next_last = {ctrl[LMP_CTRL_SEG_CFG], crit && ctrl[LMP_CTRL_UP_ACT]};
    next_tx = '0;
    next_fwd_present = fwd_present;
    next_fwd_active = fwd_active && crit;
    next_fwd_added = fwd_added;
    // Poll side: a report answers the outstanding enquiry
    if (rx_ok)
    begin
      next_wait_rep = 1'b0;
      next_umon = lmp_event(umon, 1'b0, ctrl[LMP_CTRL_FAST], thr, win);
      if (link.p2d.rep_full)
      begin
        next_fwd_present = link.p2d.present;
        next_fwd_active = link.p2d.active && crit;
        next_fwd_added = link.p2d.added;
      end
    end
    // Poll side: timer expiry sends the next enquiry
    if (tick)
    begin
      next_poll_sec = poll_sec + 5'h1;
      if (next_poll_sec >= cfg[LMP_CFG_POLL_LSB +: 5])
      begin
        next_poll_sec = 5'h0;
        if (next_wait_rep)
        begin
          next_umon = lmp_event(umon, 1'b1, ctrl[LMP_CTRL_FAST], thr, win);
        end
        next_poll_no = poll_no + 8'h1;
        next_tx.enq = 1'b1;
        next_tx.enq_full = (next_poll_no >= full_n);
        if (next_tx.enq_full)
        begin
          next_poll_no = 8'h0;
        end
        next_tx_seq = tx_seq + 8'h1;
        next_tx.enq_seq = next_tx_seq;
        next_wait_rep = 1'b1;
      end
    end
    // Answer side: every enquiry is answered and restarts the verify timer
    if (link.p2d.enq)
    begin
      next_ver_sec = 5'h0;
      next_nmon = lmp_event(nmon, 1'b0, ctrl[LMP_CTRL_FAST], thr, win);
      next_tx.rep = 1'b1;
      next_tx.rep_ack = link.p2d.enq_seq;
      next_tx.rep_full = link.p2d.enq_full || pend;
      next_tx.present = ctrl[LMP_CTRL_SEG_CFG];
      next_tx.active = crit && ctrl[LMP_CTRL_UP_ACT];
      next_tx.added = added_pend && ctrl[LMP_CTRL_SEG_CFG];
      if (next_tx.rep_full)
      begin
        next_pend = 1'b0;
        next_added_pend = 1'b0;
      end
    end
    else if (tick)
    begin
      next_ver_sec = ver_sec + 5'h1;
      if (next_ver_sec >= cfg[LMP_CFG_VER_LSB +: 5])
      begin
        next_ver_sec = 5'h0;
        next_nmon = lmp_event(nmon, 1'b1, ctrl[LMP_CTRL_FAST], thr, win);
      end
    end
    // A status change arriving now survives the clear above
    if (next_last != last)
    begin
      next_pend = 1'b1;
    end
    if (next_last[1] && !last[1])
    begin
      next_added_pend = 1'b1;
    end
    // Disabled procedures hold all but the pending report flags and the last status cleared and non-operational
    if (!en)
    begin
      next_tick_cnt = 32'h0;
      next_poll_sec = 5'h0;
      next_poll_no = 8'h0;
      next_tx_seq = 8'h0;
      next_wait_rep = 1'b0;
      next_umon = LMP_MON_RST;
      next_ver_sec = 5'h0;
      next_nmon = LMP_MON_RST;
      next_tx = '0;
      next_fwd_active = 1'b0;
      next_fwd_present = 1'b0;
      next_fwd_added = 1'b0;
    end
  end

  // Procedure state flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h0;
      poll_sec <= 5'h0;
      poll_no <= 8'h0;
      tx_seq <= 8'h0;
      wait_rep <= 1'b0;
      umon <= LMP_MON_RST;
      ver_sec <= 5'h0;
      nmon <= LMP_MON_RST;
      pend <= 1'b0;
      added_pend <= 1'b0;
      last <= 2'h0;
      tx <= '0;
      fwd_present <= 1'b0;
      fwd_active <= 1'b0;
      fwd_added <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      poll_sec <= next_poll_sec;
      poll_no <= next_poll_no;
      tx_seq <= next_tx_seq;
      wait_rep <= next_wait_rep;
      umon <= next_umon;
      ver_sec <= next_ver_sec;
      nmon <= next_nmon;
      pend <= next_pend;
      added_pend <= next_added_pend;
      last <= next_last;
      tx <= next_tx;
      fwd_present <= next_fwd_present;
      fwd_active <= next_fwd_active;
      fwd_added <= next_fwd_added;
    end
  end

endmodule : lmp_monitor

// *** hw/lmp_peer.sv ***
// Peer network end: polls on its own timer and answers every enquiry
module lmp_peer
  import lmp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LMP_TICK_CYCLES
)
(
  input wire logic presetn,
  lmp_link_if.peer link,
  input wire logic enable,
  input wire logic [7:0] full_status_poll_count,
  input wire logic seg_present,
  input wire logic seg_active,
  input wire logic seg_added,
  output logic link_up,
  output logic rx_present,
  output logic rx_active,
  output logic rx_added
);

  // ***************************************************
  // Poll and answer procedures
  // ***************************************************
  logic [31:0] tick_cnt; // Cycles within the current second
  logic [4:0] poll_sec; // Poll timer seconds, shared default
  logic [7:0] poll_no; // Polls since last full request
  logic [7:0] tx_seq; // Last enquiry sequence
  logic wait_rep; // Enquiry outstanding
  lmp_mon_s mon; // Link monitor of the poll side
  lmp_msg_s tx; // Outgoing message
  logic [31:0] next_tick_cnt;
  logic [4:0] next_poll_sec;
  logic [7:0] next_poll_no;
  logic [7:0] next_tx_seq;
  logic next_wait_rep;
  lmp_mon_s next_mon;
  lmp_msg_s next_tx;
  logic next_rx_present;
  logic next_rx_active;
  logic next_rx_added;
  logic tick; // One-second strobe

  assign tick = (tick_cnt == TICK_CYCLES - 1);
  assign link.p2d = tx;
  assign link_up = mon.op;

  // Poll on timer expiry and answer enquiries in the same cycles
  always_comb
  begin
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_poll_sec = poll_sec;
    next_poll_no = poll_no;
    next_tx_seq = tx_seq;
    next_wait_rep = wait_rep;
    next_mon = mon;
    next_tx = '0;
    next_rx_present = rx_present;
    next_rx_active = rx_active;
    next_rx_added = rx_added;
    // Report for the outstanding enquiry
    if (link.d2p.rep && wait_rep && (link.d2p.rep_ack == tx_seq))
    begin
      next_wait_rep = 1'b0;
      next_mon = lmp_event(mon, 1'b0, 1'b0, LMP_ERR_THR_DEF[3:0], LMP_WINDOW_DEF[3:0]);
      if (link.d2p.rep_full)
      begin
        next_rx_present = link.d2p.present;
        next_rx_active = link.d2p.active;
        next_rx_added = link.d2p.added;
      end
    end
    // Timer and counts fixed at the monitor end defaults; only the full count is an input
    if (tick)
    begin
      next_poll_sec = poll_sec + 5'h1;
      if (next_poll_sec >= LMP_POLL_T_DEF[4:0])
      begin
        next_poll_sec = 5'h0;
        if (next_wait_rep)
        begin
          next_mon = lmp_event(mon, 1'b1, 1'b0, LMP_ERR_THR_DEF[3:0], LMP_WINDOW_DEF[3:0]);
        end
        next_poll_no = poll_no + 8'h1;
        next_tx.enq = 1'b1;
        next_tx.enq_full = (next_poll_no >= full_status_poll_count);
        if (next_tx.enq_full)
        begin
          next_poll_no = 8'h0;
        end
        next_tx_seq = tx_seq + 8'h1;
        next_tx.enq_seq = next_tx_seq;
        next_wait_rep = 1'b1;
      end
    end
    // Answer side runs alongside the poll side
    if (link.d2p.enq)
    begin
      next_tx.rep = 1'b1;
      next_tx.rep_ack = link.d2p.enq_seq;
      next_tx.rep_full = link.d2p.enq_full;
      next_tx.present = seg_present;
      next_tx.active = seg_active;
      next_tx.added = seg_added;
    end
    // Disabled end holds everything cleared
    if (!enable)
    begin
      next_tick_cnt = 32'h0;
      next_poll_sec = 5'h0;
      next_poll_no = 8'h0;
      next_tx_seq = 8'h0;
      next_wait_rep = 1'b0;
      next_mon = LMP_MON_RST;
      next_tx = '0;
      next_rx_present = 1'b0;
      next_rx_active = 1'b0;
      next_rx_added = 1'b0;
    end
  end

  // Procedure state flops
  always_ff @(posedge link.pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h0;
      poll_sec <= 5'h0;
      poll_no <= 8'h0;
      tx_seq <= 8'h0;
      wait_rep <= 1'b0;
      mon <= LMP_MON_RST;
      tx <= '0;
      rx_present <= 1'b0;
      rx_active <= 1'b0;
      rx_added <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      poll_sec <= next_poll_sec;
      poll_no <= next_poll_no;
      tx_seq <= next_tx_seq;
      wait_rep <= next_wait_rep;
      mon <= next_mon;
      tx <= next_tx;
      rx_present <= next_rx_present;
      rx_active <= next_rx_active;
      rx_added <= next_rx_added;
    end
  end

endmodule : lmp_peer

// *** bench/lmp_link_props.sv ***
// Wire checker between the monitor end and the peer end
module lmp_link_props
  import lmp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire lmp_msg_s d2p,
  input wire lmp_msg_s p2d
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] last_seq; // Last monitor enquiry number
  // Remember each enquiry number
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_seq <= 8'h00;
    else if (d2p.enq)
      last_seq <= d2p.enq_seq;
  end
  // Full enquiries of each end
  sequence s_full_p;
    p2d.enq && p2d.enq_full;
  endsequence
  sequence s_full_d;
    d2p.enq && d2p.enq_full;
  endsequence
  // ****
  // Properties
  // ****
  AST_PEER_REP:
    assert property (p2d.rep |-> $past(d2p.enq) && p2d.rep_ack == $past(d2p.enq_seq))
    else $error("Peer report without matching enquiry");
  AST_MON_REP:
    assert property (d2p.rep |-> $past(p2d.enq) && d2p.rep_ack == $past(p2d.enq_seq))
    else $error("Monitor report without matching enquiry");
  AST_SEQ_STEP:
    assert property (d2p.enq && last_seq != 8'h00 |->
      d2p.enq_seq == last_seq + 8'h01 || d2p.enq_seq == 8'h01)
    else $error("Enquiry number skipped");
  AST_MON_GAP:
    assert property (d2p.enq |=> !d2p.enq [*8])
    else $error("Monitor enquiries too close");
  AST_PEER_GAP:
    assert property (p2d.enq |=> !p2d.enq [*8])
    else $error("Peer enquiries too close");
  AST_ENQ_IDLE:
    assert property (!d2p.enq |-> d2p.enq_seq == 8'h00 && !d2p.enq_full)
    else $error("Enquiry fields outside pulse");
  AST_ACT_PRES:
    assert property (d2p.rep && d2p.active |-> d2p.present)
    else $error("Active sent for absent segment");
  AST_ADD_FULL:
    assert property (d2p.rep && d2p.added |-> d2p.rep_full)
    else $error("New bit in a short report");
  AST_MON_FULL:
    assert property (s_full_p ##1 d2p.rep |-> d2p.rep_full)
    else $error("Full request answered short");
  AST_PEER_FULL:
    assert property (s_full_d ##1 p2d.rep |-> p2d.rep_full)
    else $error("Peer answered full request short");
endmodule : lmp_link_props

// *** bench/tb.sv ***
// Bench joining the monitor and the peer end
module tb
  import lmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err_s, lup, rxp, rxa, rxd, fp, fa, fd;
  logic pen = 1'b1; // Peer enable
  logic sp = 1'b1; // Peer segment present
  logic sa = 1'b1; // Peer segment active
  logic sd = 1'b1; // Peer segment new
  logic [7:0] pfc = 8'h03; // Peer full poll count
  int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 4, nd = 0, np = 0, mfc = 6;
  lmp_link_if link (.pclk(pclk));
  lmp_monitor #(.TICK_CYCLES(4)) lmp_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.dev),
    .fwd_present(fp), .fwd_active(fa), .fwd_added(fd));
  lmp_peer #(.TICK_CYCLES(4)) lmp_peer_inst (.presetn(presetn), .link(link.peer),
    .enable(pen), .full_status_poll_count(pfc), .seg_present(sp), .seg_active(sa),
    .seg_added(sd), .link_up(lup), .rx_present(rxp), .rx_active(rxa), .rx_added(rxd));
  lmp_link_props lmp_link_props_inst (.pclk(pclk), .presetn(presetn),
    .d2p(link.d2p), .p2d(link.p2d));
  // ****
  // Helpers
  // ****
  // Clock and hang guard
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Wait for a count of enquiries, then let the answer settle
  task automatic wt(ref int c, input int n);
    while (c < n) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : wt
  function automatic logic [7:0] lim(input int x, input int lo, input int hi);
    return (x < lo) ? lo[7:0] : (x > hi) ? hi[7:0] : x[7:0];
  endfunction : lim
  // Expected read back of a configuration write
  function automatic logic [31:0] ecfg(input logic [31:0] w);
    logic [7:0] t, n, p, e;
    t = lim(w[11:8], 1, 10);
    n = lim(w[15:12], 1, 10);
    p = lim(w[20:16], 5, 30);
    e = lim(w[28:24], 5, 30);
    return {3'b0, e[4:0], 3'b0, p[4:0], n[3:0], t[3:0], lim(w[7:0], 1, 255)};
  endfunction : ecfg
  // Enquiry model of both ends
  always @(posedge pclk)
  begin
    if (link.d2p.enq === 1'b1)
    begin
      nd++;
      cmp("mon seq", nd, link.d2p.enq_seq);
      cmp("mon full", (nd % mfc) == 0, link.d2p.enq_full);
    end
    if (link.p2d.enq === 1'b1)
    begin
      np++;
      cmp("peer full", (np % 3) == 0, link.p2d.enq_full);
    end
  end
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LMP_CFG_OFS, 32'h0);
    cmp("cfg reset", 32'h0F0A_4306, rd);
    cmp("cfg err", 1'b0, err_s);
    cmp("ready", 1'b1, pready);
    apb(1'b0, 12'hFFC, 32'h0);
    cmp("unmapped", 1'b1, err_s);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 32'h1F01_FF00 : $random(seed);
      apb(1'b1, LMP_CFG_OFS, v);
      apb(1'b0, LMP_CFG_OFS, 32'h0);
      cmp("cfg", ecfg(v), rd);
    end
    apb(1'b1, LMP_CFG_OFS, 32'h0F0A_4302);
    mfc = 2;
    np = 0;
    apb(1'b1, LMP_CTRL_OFS, 32'h1);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("start", 2'b00, rd[1:0]);
    wt(nd, 3);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("user op 3", 1'b0, rd[0]);
    wt(nd, 4);
    wt(np, 4);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("both op", 2'b11, rd[1:0]);
    cmp("peer up", 1'b1, lup);
    apb(1'b1, LMP_CTRL_OFS, 32'h3D);
    wt(np, np + 1);
    cmp("rx new", 3'b111, {rxp, rxa, rxd});
    wt(nd, nd + 2);
    cmp("fwd", 3'b111, {fp, fa, fd});
    apb(1'b1, LMP_CTRL_OFS, 32'h35);
    // The drop registers one edge after the write lands
    @(posedge pclk);
    cmp("fwd drop", 2'b10, {fp, fa});
    wt(np, np + 1);
    cmp("rx drop", 2'b10, {rxp, rxa});
    sa <= 1'b0;
    apb(1'b1, LMP_CTRL_OFS, 32'h3D);
    wt(nd, nd + 2);
    wt(np, np + 1);
    cmp("indep", 2'b01, {fa, rxa});
    nd = 0;
    apb(1'b1, LMP_CTRL_OFS, 32'h0);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("off", 5'h00, rd[4:0]);
    apb(1'b1, LMP_CTRL_OFS, 32'h3);
    wt(nd, 1);
    pen <= 1'b0;
    np = 0;
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("fast", 1'b1, rd[0]);
    wt(nd, 4);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("two err", 5'h05, {rd[11:8], rd[0]});
    wt(nd, 5);
    apb(1'b0, LMP_STAT_OFS, 32'h0);
    cmp("three err", 5'h06, {rd[11:8], rd[0]});
    cmp("peer off", 4'h0, {lup, rxp, rxa, rxd});
    stop_test;
  end
endmodule : tb
